// file: logic/charger_detect_sequencer.sv
// transceiver-side registers and line reporting used for charger detection
// assumes an Avalon-MM master on core_clk_i and analog comparators synchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "charger_detect_params.svh"

module charger_detect_sequencer
    import charger_detect_pkg::*;
#(
    parameter int unsigned RID_MEAS_CYCLES = `RID_MEAS_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // avalon-mm register slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog comparators and pins
    input wire logic id_grounded_i,
    input wire logic session_valid_i,
    input wire logic dp_level_i,
    input wire logic dm_level_i,
    input wire logic [2:0] id_code_i,
    input wire logic sync_mode_i,
    // analog controls
    output func_ctrl_type func_ctrl_o,
    output logic id_pullup_enable_o,
    output logic dp_charger_pullup_o,
    output logic dm_charger_pullup_o,
    output logic swap_dp_dm_o,
    // link data byte and interrupt
    output logic [7:0] link_data_o,
    output logic irq_o
);

    logic [7:0] func_ctrl;
    logic [7:0] otg_ctrl;
    logic [7:0] rid_reg;
    logic [7:0] power;
    logic [2:0] irq_enable;
    logic [2:0] irq_status;
    logic ack;
    logic [7:0] index;
    logic wr_take;
    logic rd_take;
    logic [7:0] wdata;
    logic [7:0] next_rid;
    logic [7:0] next_power;
    logic meter_finished;
    logic [2:0] meter_code;
    line_state_type line_state;
    logic session_prev;
    logic id_gnd_prev;
    logic [2:0] irq_event;
    logic rid_read;
    logic [7:0] rxcmd;
    logic [7:0] read_mux;

    // ============================================================
    // avalon handshake: one wait state, then the access completes
    // ack drops after each completion, so back-to-back requests each cost one wait state
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign index = avs_address[9:2];
    assign wdata = avs_writedata[7:0];
    assign wr_take = avs_write && ack;
    assign rd_take = avs_read && ack;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    // ============================================================
    // line state, optionally swapped
    // swap lets the board cross the pins; receivers and reporting follow it
    always_comb begin
        line_state.line_level_0 = power[`POWER_SWAP_BIT] ? dm_level_i : dp_level_i;
        line_state.line_level_1 = power[`POWER_SWAP_BIT] ? dp_level_i : dm_level_i;
    end

    // ============================================================
    // function control
    // fields are not decoded here; the analog front end takes the struct as is
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            func_ctrl <= `FUNC_CTRL_RESET;
        end else if (wr_take && index == `IDX_FUNC_CTRL) begin
            func_ctrl <= wdata;
        end
    end

    assign func_ctrl_o = func_ctrl_type'(func_ctrl);

    // ============================================================
    // otg control: id pull-up for the resistance measurement
    // only bit 0 acts; the other bits are kept for software
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            otg_ctrl <= `OTG_CTRL_RESET;
        end else if (wr_take && index == `IDX_OTG_CTRL) begin
            otg_ctrl <= wdata;
        end
    end

    assign id_pullup_enable_o = otg_ctrl[`OTG_ID_PULLUP_BIT];

    // ============================================================
    // power management: write, set, clear
    // bit 0 is reserved: masked on every path so it always reads zero
    always_comb begin
        next_power = power;
        if (wr_take) begin
            case (index)
                `IDX_POWER_WRITE: next_power = wdata;
                `IDX_POWER_SET: next_power = power | wdata;
                `IDX_POWER_CLEAR: next_power = power & ~wdata;
                default: next_power = power;
            endcase
        end
        next_power = next_power & `POWER_STORE_MASK;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            power <= `POWER_RESET;
        end else begin
            power <= next_power;
        end
    end

    assign dp_charger_pullup_o = power[`POWER_DP_PULLUP_BIT];
    assign dm_charger_pullup_o = power[`POWER_DM_PULLUP_BIT];
    assign swap_dp_dm_o = power[`POWER_SWAP_BIT];

    // ============================================================
    // resistance conversion register
    assign rid_read = rd_take && (index == `IDX_RID_WRITE || index == `IDX_RID_SET
        || index == `IDX_RID_CLEAR);

    always_comb begin
        next_rid = rid_reg;
        if (rid_read) begin
            next_rid[`RID_DONE_BIT] = 1'b0;
        end
        // capture after the read clear: a finish in that cycle is not lost
        if (meter_finished) begin
            next_rid[2:0] = meter_code;
            next_rid[`RID_DONE_BIT] = 1'b1;
            next_rid[`RID_GO_BIT] = 1'b0;
        end
        // software write applied last: it wins over the capture for go and code
        if (wr_take) begin
            case (index)
                `IDX_RID_WRITE: begin
                    next_rid = (next_rid & ~`RID_STORE_MASK) | (wdata & `RID_STORE_MASK);
                end
                `IDX_RID_SET: next_rid = next_rid | (wdata & `RID_STORE_MASK);
                `IDX_RID_CLEAR: next_rid = next_rid & ~(wdata & `RID_STORE_MASK);
                default: next_rid = next_rid;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rid_reg <= `RID_RESET;
        end else begin
            rid_reg <= next_rid;
        end
    end

    // go is a level: the meter restarts only after go has auto-cleared
    // timed conversion
    resistance_meter #(
        .MEAS_CYCLES(RID_MEAS_CYCLES)
    ) u_meter (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .go_i(rid_reg[`RID_GO_BIT]),
        .id_code_i(id_code_i),
        .finished_o(meter_finished),
        .code_o(meter_code)
    );

    // ============================================================
    // interrupt events: comparator changes and conversion end
    // prev flops reset low: a comparator already high at reset reports one change
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            session_prev <= 1'b0;
            id_gnd_prev <= 1'b0;
        end else begin
            session_prev <= session_valid_i;
            id_gnd_prev <= id_grounded_i;
        end
    end

    always_comb begin
        irq_event = 3'h0;
        irq_event[`IRQ_SESSION_BIT] = session_valid_i ^ session_prev;
        irq_event[`IRQ_ID_GND_BIT] = id_grounded_i ^ id_gnd_prev;
        irq_event[`IRQ_RID_DONE_BIT] = meter_finished && rid_reg[`RID_INT_EN_BIT];
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_enable <= `IRQ_ENABLE_RESET;
        end else if (wr_take && index == `IDX_IRQ_ENABLE) begin
            irq_enable <= wdata[2:0];
        end
    end

    // status stays set while disabled; enabling later raises the line at once
    sticky_irq u_irq (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .event_i(irq_event),
        .clear_i(wr_take && index == `IDX_IRQ_CLEAR),
        .clear_mask_i(wdata[2:0]),
        .enable_i(irq_enable),
        .status_o(irq_status),
        .irq_o(irq_o)
    );

    // ============================================================
    // link data byte
    // registered so the byte never changes mid-cycle under the link's sample
    always_comb begin
        rxcmd = 8'h00;
        rxcmd[1:0] = line_state;
        rxcmd[3] = session_valid_i;
        rxcmd[6] = !id_grounded_i;
        rxcmd[7] = irq_o;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            link_data_o <= 8'h00;
        end else if (sync_mode_i) begin
            link_data_o <= rxcmd;
        end else begin
            // interrupt on data 3, line state on data 1:0
            link_data_o <= {4'h0, irq_o, 1'b0, line_state};
        end
    end

    // ============================================================
    // register read; unmapped reads return zero
    always_comb begin
        case (index)
            `IDX_FUNC_CTRL: read_mux = func_ctrl;
            `IDX_OTG_CTRL: read_mux = otg_ctrl;
            `IDX_DEBUG: read_mux = {6'h00, line_state};
            `IDX_RID_WRITE, `IDX_RID_SET, `IDX_RID_CLEAR: read_mux = rid_reg;
            `IDX_POWER_WRITE, `IDX_POWER_SET, `IDX_POWER_CLEAR: read_mux = power;
            `IDX_IRQ_STATUS: read_mux = {5'h00, irq_status};
            `IDX_IRQ_ENABLE: read_mux = {5'h00, irq_enable};
            default: read_mux = 8'h00;
        endcase
    end

    // data stand during the cycle waitrequest is low
    // loaded on the request edge and held through the completion edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= {24'h00_0000, read_mux};
        end
    end

endmodule // charger_detect_sequencer

`default_nettype wire

// file: logic/resistance_meter.sv
// id resistance converter: times one measurement and captures the code
// assumes go is a level held until finished pulses; code input is the analog ladder result
`timescale 1ns/1ps
`default_nettype none

module resistance_meter
    import charger_detect_pkg::*;
#(
    parameter int unsigned MEAS_CYCLES = 7050
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // control
    input wire logic go_i,
    input wire logic [2:0] id_code_i,
    // result
    output logic finished_o,
    output logic [2:0] code_o
);

    meter_state_type state;
    logic [15:0] count;

    // ============================================================
    // sequencer
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= METER_IDLE;
            count <= 16'h0000;
        end else begin
            case (state)
                METER_IDLE: begin
                    count <= 16'h0000;
                    if (go_i) begin
                        state <= METER_BUSY;
                    end
                end
                METER_BUSY: begin
                    if (count == 16'(MEAS_CYCLES - 1)) begin
                        state <= METER_DONE;
                    end else begin
                        count <= count + 16'h0001;
                    end
                end
                METER_DONE: begin
                    state <= METER_IDLE;
                end
                default: begin
                    state <= METER_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // result
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            finished_o <= 1'b0;
            code_o <= 3'h0;
        end else begin
            finished_o <= (state == METER_BUSY) && (count == 16'(MEAS_CYCLES - 1));
            // three-bit code captured at the end
            if ((state == METER_BUSY) && (count == 16'(MEAS_CYCLES - 1))) begin
                code_o <= id_code_i;
            end
        end
    end

endmodule // resistance_meter

`default_nettype wire

// file: logic/sticky_irq.sv
// sticky event flags, enable gating and one level interrupt
// assumes clear_i is a one-cycle write strobe qualified by clear_mask_i
`timescale 1ns/1ps
`default_nettype none

module sticky_irq (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // events and software control
    input wire logic [2:0] event_i,
    input wire logic clear_i,
    input wire logic [2:0] clear_mask_i,
    input wire logic [2:0] enable_i,
    // state
    output logic [2:0] status_o,
    output logic irq_o
);

    // ============================================================
    // flags: an event in the clear cycle wins
    for (genvar i = 0; i < 3; i++) begin : g_flag
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                status_o[i] <= 1'b0;
            end else if (event_i[i]) begin
                status_o[i] <= 1'b1;
            end else if (clear_i && clear_mask_i[i]) begin
                status_o[i] <= 1'b0;
            end
        end
    end

    assign irq_o = |(status_o & enable_i);

endmodule // sticky_irq

`default_nettype wire

// file: shared/charger_detect_params.svh
// offsets, field positions, reset values and timing counts of the charger-detect block
// assumes register indices are word indices: byte address is four times the index
`ifndef CHARGER_DETECT_PARAMS_SVH
`define CHARGER_DETECT_PARAMS_SVH

// ============================================================
// register indices
`define IDX_FUNC_CTRL 8'h04
`define IDX_OTG_CTRL 8'h0A
`define IDX_DEBUG 8'h15
`define IDX_RID_WRITE 8'h36
`define IDX_RID_SET 8'h37
`define IDX_RID_CLEAR 8'h38
`define IDX_POWER_WRITE 8'h39
`define IDX_POWER_SET 8'h3A
`define IDX_POWER_CLEAR 8'h3B
`define IDX_IRQ_STATUS 8'h40
`define IDX_IRQ_CLEAR 8'h41
`define IDX_IRQ_ENABLE 8'h42

// ============================================================
// field positions
`define OTG_ID_PULLUP_BIT 0
`define RID_DONE_BIT 3
`define RID_GO_BIT 4
`define RID_INT_EN_BIT 6
`define POWER_SWAP_BIT 1
`define POWER_DP_PULLUP_BIT 4
`define POWER_DM_PULLUP_BIT 5
`define IRQ_SESSION_BIT 0
`define IRQ_ID_GND_BIT 1
`define IRQ_RID_DONE_BIT 2

// ============================================================
// reset values and masks
`define FUNC_CTRL_RESET 8'h00
`define OTG_CTRL_RESET 8'h00
`define RID_RESET 8'h00
`define RID_STORE_MASK 8'h77
`define POWER_RESET 8'h04
`define POWER_STORE_MASK 8'hFE
`define IRQ_ENABLE_RESET 3'h0

// ============================================================
// timing
`define CORE_CLK_PERIOD_NS 40
`define RID_MEAS_TIME_NS 282000
`define RID_MEAS_CYCLES ((`RID_MEAS_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

// file: shared/charger_detect_pkg.sv
// types shared by the charger-detect block
// assumes nothing beyond a SystemVerilog compiler
package charger_detect_pkg;

    // function control fields, high bit first
    typedef struct packed {
        logic spare;
        logic suspend_n;
        logic phy_reset;
        logic [1:0] op_mode;
        logic term_select;
        logic [1:0] xcvr_select;
    } func_ctrl_type;

    typedef struct packed {
        logic line_level_1;
        logic line_level_0;
    } line_state_type;

    typedef enum logic [1:0] {
        METER_IDLE = 2'b00,
        METER_BUSY = 2'b01,
        METER_DONE = 2'b11
    } meter_state_type;

endpackage

// file: testbench/charger_detect_sequencer_sva.sv
// checker for the charger-detect register block
// assumes it is bound to charger_detect_sequencer and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module charger_detect_sva
    import charger_detect_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register bus
    input wire logic [9:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // pins and controls
    input wire logic session_valid_i,
    input wire logic dp_level_i,
    input wire logic dm_level_i,
    input wire logic sync_mode_i,
    input wire func_ctrl_type func_ctrl_o,
    input wire logic dp_charger_pullup_o,
    input wire logic dm_charger_pullup_o,
    input wire logic swap_dp_dm_o,
    input wire logic [7:0] link_data_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire logic wr_w = avs_write && !avs_waitrequest;
    wire logic [7:0] idx_w = avs_address[9:2];

    property p_fs_mode;
        wr_w && idx_w == 8'h04 && avs_writedata[7:0] == 8'h49 |=> func_ctrl_o == 8'h49;
    endproperty
    a_fs_mode: assert property (p_fs_mode) else $error("function control not 49");
    property p_dp_set;
        wr_w && idx_w == 8'h3A && avs_writedata[5:4] == 2'b01
            |=> dp_charger_pullup_o && dm_charger_pullup_o == $past(dm_charger_pullup_o);
    endproperty
    a_dp_set: assert property (p_dp_set) else $error("plus pull-up set wrong");
    property p_dm_set;
        wr_w && idx_w == 8'h3A && avs_writedata[7:0] == 8'h20
            |=> dm_charger_pullup_o && dp_charger_pullup_o == $past(dp_charger_pullup_o);
    endproperty
    a_dm_set: assert property (p_dm_set) else $error("minus pull-up set wrong");
    property p_replace;
        wr_w && idx_w == 8'h39 |=> {dm_charger_pullup_o, dp_charger_pullup_o, swap_dp_dm_o}
            == $past({avs_writedata[5], avs_writedata[4], avs_writedata[1]});
    endproperty
    a_replace: assert property (p_replace) else $error("power write not replaced");
    property p_clear;
        wr_w && idx_w == 8'h3B && avs_writedata[4] |=> !dp_charger_pullup_o;
    endproperty
    a_clear: assert property (p_clear) else $error("power clear missed");
    property p_sess;
        sync_mode_i |=> link_data_o[3] == $past(session_valid_i);
    endproperty
    a_sess: assert property (p_sess) else $error("session bit wrong in sync mode");
    property p_irq_line;
        !sync_mode_i |=> link_data_o[3] == $past(irq_o);
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("data 3 not interrupt");
    property p_lines;
        !swap_dp_dm_o |=> link_data_o[1:0] == $past({dm_level_i, dp_level_i});
    endproperty
    a_lines: assert property (p_lines) else $error("line state not on data 1:0");
endmodule // charger_detect_sva

bind charger_detect_sequencer charger_detect_sva u_sva (.core_clk_i, .reset_i, .avs_address,
    .avs_write, .avs_writedata, .avs_waitrequest, .session_valid_i, .dp_level_i, .dm_level_i,
    .sync_mode_i, .func_ctrl_o, .dp_charger_pullup_o, .dm_charger_pullup_o, .swap_dp_dm_o,
    .link_data_o, .irq_o);

`default_nettype wire

// file: testbench/line_env_model.sv
// dp/dm line model of the attached party: charger or host
// assumes pull-up enables come straight from the device outputs
`timescale 1ns/1ps
`default_nettype none

module line_env_model (
    // pull-up enables from the device
    input wire logic dp_pullup_i,
    input wire logic dm_pullup_i,
    // attached party, high for a charger
    input wire logic charger_i,
    // single-ended receiver levels
    output logic dp_level_o,
    output logic dm_level_o
);
    // shorted pins read high once either pull-up is on
    // a host's strong pull-downs win over the weak pull-ups
    assign dp_level_o = charger_i && (dp_pullup_i || dm_pullup_i);
    assign dm_level_o = dp_level_o;
endmodule // line_env_model

`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the charger-detect register block
// assumes the design package and header on the include path, one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int MEAS = 20;
    localparam int LIMIT = 3000;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic id_grounded_i = 1'b0;
    logic session_valid_i = 1'b0;
    logic sync_mode_i = 1'b1;
    logic [2:0] id_code_i = 3'h2;
    logic charger = 1'b1;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest, dp_level, dm_level, id_pullup, dp_pu, dm_pu, swap, irq;
    wire logic [7:0] func_ctrl, link_data;
    logic [31:0] rdata;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    always #20 core_clk_i = ~core_clk_i;

    charger_detect_sequencer #(.RID_MEAS_CYCLES(MEAS)) dut (.core_clk_i, .reset_i,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .id_grounded_i, .session_valid_i, .dp_level_i(dp_level), .dm_level_i(dm_level),
        .id_code_i, .sync_mode_i, .func_ctrl_o(func_ctrl), .id_pullup_enable_o(id_pullup),
        .dp_charger_pullup_o(dp_pu), .dm_charger_pullup_o(dm_pu), .swap_dp_dm_o(swap),
        .link_data_o(link_data), .irq_o(irq));
    line_env_model env (.dp_pullup_i(dp_pu), .dm_pullup_i(dm_pu), .charger_i(charger),
        .dp_level_o(dp_level), .dm_level_o(dm_level));

    // ========
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge; read data taken there
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk_i);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk_i);
        end
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, exp, rdata);
    endtask

    // ========
    // scenarios
    task automatic t_regs;
        rdc("func_ctrl", 8'h04, 32'h0000_0000);
        rdc("power", 8'h39, 32'h0000_0004);
        rdc("unmapped", 8'h20, 32'h0000_0000);
        wr(8'h40, 8'h07);
        rdc("status", 8'h40, 32'h0000_0000);
        wr(8'h39, 8'h03);
        rdc("power replaced", 8'h3B, 32'h0000_0002);
        chk("swap", 1, swap);
        wr(8'h39, 8'h04);
    endtask
    task automatic t_rid;
        int n;
        n = 0;
        wr(8'h41, 8'h07);
        id_grounded_i <= 1'b1;
        wr(8'h0A, 8'h01);
        chk("id pullup", 1, id_pullup);
        wr(8'h37, 8'h50);
        do begin
            bus(1'b0, 8'h36, 8'h00);
            n += 3;
        end while (rdata[3] !== 1'b1 && n < 300);
        chk("rid done code", 32'h0000_004A, rdata);
        chk("meas time", 1, n > MEAS - 4 && n < MEAS + 10);
        rdc("done cleared", 8'h36, 32'h0000_0042);
        rdc("status", 8'h40, 32'h0000_0006);
    endtask
    task automatic t_short(input logic chg, input logic [1:0] ls);
        charger <= chg;
        session_valid_i <= 1'b1;
        wr(8'h04, 8'h49);
        chk("func_ctrl", 32'h0000_0049, func_ctrl);
        wr(8'h3A, 8'h10);
        chk("pullups", 2'b01, {dm_pu, dp_pu});
        wr(8'h3A, 8'h20);
        chk("pullups", 2'b11, {dm_pu, dp_pu});
        repeat (4) @(posedge core_clk_i);
        rdc("debug", 8'h15, {30'h0, ls});
        chk("link lines", ls, link_data[1:0]);
        chk("link session", 1, link_data[3]);
        rdc("power", 8'h39, 32'h0000_0034);
        wr(8'h3B, 8'h30);
        rdc("power cleared", 8'h3A, 32'h0000_0004);
    endtask
    task automatic t_irq;
        wr(8'h41, 8'h07);
        sync_mode_i <= 1'b0;
        session_valid_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("masked irq", 0, irq);
        chk("link irq", 0, link_data[3]);
        rdc("status", 8'h40, 32'h0000_0001);
        wr(8'h42, 8'h01);
        @(posedge core_clk_i);
        chk("irq", 1, irq);
        chk("link irq", 1, link_data[3]);
        wr(8'h41, 8'h01);
        chk("irq cleared", 0, irq);
        rdc("enable", 8'h42, 32'h0000_0001);
        rdc("clear reads", 8'h41, 32'h0000_0000);
        sync_mode_i <= 1'b1;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        t_regs();
        t_rid();
        t_short(1'b1, 2'b11);
        t_short(1'b0, 2'b00);
        t_irq();
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
